// ==== src/sop_array_pkg.sv ====
// Purpose: Shared constants and types for the sum-of-products macrocell array.
// Assumes: One clock; registers reached over a plain strobe port.
// Notes: Fuse bit set means the literal is removed from the product term.
package sop_array_pkg;

   // Array geometry
   localparam int NUM_CELLS = 10;
   localparam int NUM_DED = 12;
   localparam int NUM_SIG = NUM_DED + NUM_CELLS;
   localparam int NUM_LIT = 2 * NUM_SIG;
   localparam int NUM_TERMS = 132;

   // Sum sizes and term layout: each cell holds its enable term, then its sum terms
   localparam int TERM_CNT[NUM_CELLS] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
   localparam int TERM_BASE[NUM_CELLS] = '{0, 9, 20, 33, 48, 65, 82, 97, 110, 121};
   localparam int PRESET_TERM = 130;
   localparam int RESET_TERM = 131;

   // Register port
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam int LO_W = 32;
   localparam int HI_W = NUM_LIT - LO_W;
   localparam logic [ADDR_W-1:0] FUSE_LAST_ADDR = 9'h107;
   localparam logic [ADDR_W-1:0] CFG_ADDR = 9'h110;
   localparam logic [ADDR_W-1:0] STATE_ADDR = 9'h111;
   localparam logic [ADDR_W-1:0] PIN_ADDR = 9'h112;

   // Per-cell configuration: comb_select_bit high = combinatorial, polarity_select_bit high = active high
   typedef struct packed {
      logic comb_select_bit;
      logic polarity_select_bit;
   } cell_cfg_t;

   localparam logic [2*NUM_CELLS-1:0] CFG_RESET = 20'h00000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

endpackage : sop_array_pkg

// ==== src/sum_term_unit.sv ====
// Purpose: OR of N product terms, each an AND over the selected literals.
// Assumes: Fuse bit high removes a literal; an all-zero fuse word ANDs x with not x.
// Notes: Also used with N of one for the enable, preset and reset terms.
`timescale 1ns/10ps
module sum_term_unit
   import sop_array_pkg::*;
#(
   parameter int N = 8
) (
   input wire logic [NUM_LIT-1:0] lits,
   input wire logic [N-1:0][NUM_LIT-1:0] fuses,
   output logic sum
);

   logic [N-1:0] term;

   // One AND per product term
   genvar k;
   generate
      for (k = 0; k < N; k++) begin : g_term
         assign term[k] = &(lits | fuses[k]);
      end
   endgenerate

   // OR of the product terms
   assign sum = |term;

endmodule : sum_term_unit

// ==== src/sop_macrocell_array.sv ====
// Purpose: Programmable AND-OR array with ten output macrocells.
// Assumes: Pins and dedicated inputs are asynchronous and pass two flip-flops.
// Notes: Combinatorial results reach pins and feedback one clock later than the sum.
//
// Summary of operation
// - Each function is an AND plane over inputs and feedback, then an OR.
// - Ten macrocells, each independently registered or combinatorial to its pin.
// - Two bits per cell: comb select high is combinatorial; polarity high is active high.
// - Sum sizes come in five pairs, eight to sixteen terms in steps of two.
// - A dedicated term enables each driver; a disabled pin of a combinatorial cell serves as input.
// - Registered cells feed their register output back into the AND plane.
// - Combinatorial cells feed back their result, or the pin level when disabled.
// - One shared term presets registers at the edge; another clears them at the same edge.
// - Preset and clear terms are shared and take no terms from the sums.
// - Power-up reset clears every macrocell register, the fuse array, the config and the pin drivers.
// - Pins turned to inputs allow twenty-two inputs down to twelve with ten outputs.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module sop_macrocell_array
   import sop_array_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_DED-1:0] ded_in,
   input wire logic [NUM_CELLS-1:0] pin_in,
   output logic [NUM_CELLS-1:0] pin_out,
   output logic [NUM_CELLS-1:0] pin_oe,
   input wire reg_req_t req,
   output logic [DATA_W-1:0] rd_data
);

   // Programmed array and configuration
   logic [NUM_TERMS-1:0][NUM_LIT-1:0] fuse;
   cell_cfg_t [NUM_CELLS-1:0] cfg;

   // Input synchronisers
   logic [NUM_DED-1:0] ded_meta;
   logic [NUM_DED-1:0] ded_sync;
   logic [NUM_CELLS-1:0] pin_meta;
   logic [NUM_CELLS-1:0] pin_sync;

   // Macrocell state and array signals
   logic [NUM_CELLS-1:0] q;
   logic [NUM_CELLS-1:0] comb_hold;
   logic [NUM_CELLS-1:0] sum;
   logic [NUM_CELLS-1:0] oe_term;
   logic [NUM_CELLS-1:0] next_q;
   logic [NUM_CELLS-1:0] pin_val;
   logic [NUM_CELLS-1:0] next_pin_out;
   logic [NUM_CELLS-1:0] fb;
   logic [NUM_SIG-1:0] sig;
   logic [NUM_LIT-1:0] lits;
   logic preset_term;
   logic reset_term;
   logic [DATA_W-1:0] next_rd_data;
   logic [7:0] fuse_idx;
   logic fuse_hit;

   // Two-stage synchronisers for all pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ded_meta <= '0;
         ded_sync <= '0;
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         ded_meta <= ded_in;
         ded_sync <= ded_meta;
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   // dedicated plus feedback
   // Signals presented to the AND plane: dedicated inputs and cell feedback
   assign sig = {fb, ded_sync};

   // true and complement
   // Each signal offers its true and complemented literal
   genvar s;
   generate
      for (s = 0; s < NUM_SIG; s++) begin : g_lit
         assign lits[2*s] = sig[s];
         assign lits[2*s+1] = ~sig[s];
      end
   endgenerate

   // shared init terms
   // Preset and clear use their own terms outside every cell's sum
   sum_term_unit #(.N(1)) u_preset (
      .lits(lits),
      .fuses(fuse[PRESET_TERM +: 1]),
      .sum(preset_term)
   );

   sum_term_unit #(.N(1)) u_reset (
      .lits(lits),
      .fuses(fuse[RESET_TERM +: 1]),
      .sum(reset_term)
   );

   // Per-cell sum, enable, next state, pin value and feedback
   genvar i;
   generate
      for (i = 0; i < NUM_CELLS; i++) begin : g_cell
         sum_term_unit #(.N(TERM_CNT[i])) u_sum (
            .lits(lits),
            .fuses(fuse[TERM_BASE[i] + 1 +: TERM_CNT[i]]),
            .sum(sum[i])
         );

         sum_term_unit #(.N(1)) u_oe (
            .lits(lits),
            .fuses(fuse[TERM_BASE[i] +: 1]),
            .sum(oe_term[i])
         );

         assign next_q[i] = reset_term ? 1'b0 : (preset_term ? 1'b1 : sum[i]);

         assign pin_val[i] = cfg[i].comb_select_bit ? sum[i] : next_q[i];
         assign next_pin_out[i] = cfg[i].polarity_select_bit ? pin_val[i] : ~pin_val[i];

         assign fb[i] = cfg[i].comb_select_bit ? (pin_oe[i] ? comb_hold[i] : pin_sync[i]) : q[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Holds the combinatorial result so feedback never forms a loop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         comb_hold <= '0;
      end else begin
         comb_hold <= sum;
      end
   end

   // per-cell output drive
   // Pin driver and enable; pin_out resets low and shows the cleared register one clock later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= oe_term;
      end
   end

   // Fuse word decode: two port words per term, low half first
   assign fuse_idx = req.addr[ADDR_W-1:1];
   assign fuse_hit = (req.addr <= FUSE_LAST_ADDR);

   // Fuse programming
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fuse <= '0;
      end else if (req.wr && fuse_hit) begin
         if (req.addr[0]) begin
            fuse[fuse_idx][NUM_LIT-1:LO_W] <= req.wdata[HI_W-1:0];
         end else begin
            fuse[fuse_idx][LO_W-1:0] <= req.wdata[LO_W-1:0];
         end
      end
   end

   // Cell configuration register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg <= CFG_RESET;
      end else if (req.wr && req.addr == CFG_ADDR) begin
         cfg <= req.wdata[2*NUM_CELLS-1:0];
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      next_rd_data = '0;
      if (fuse_hit) begin
         if (req.addr[0]) begin
            next_rd_data[HI_W-1:0] = fuse[fuse_idx][NUM_LIT-1:LO_W];
         end else begin
            next_rd_data[LO_W-1:0] = fuse[fuse_idx][LO_W-1:0];
         end
      end else begin
         case (req.addr)
            CFG_ADDR: begin
               next_rd_data[2*NUM_CELLS-1:0] = cfg;
            end
            STATE_ADDR: begin
               next_rd_data[NUM_CELLS-1:0] = q;
            end
            PIN_ADDR: begin
               next_rd_data[2*NUM_CELLS-1:0] = {pin_oe, pin_sync};
            end
            default: begin
               next_rd_data = '0;
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (req.rd) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= '0;
      end
   end

endmodule : sop_macrocell_array

// ==== bench/sop_array_checker.sv ====
// Purpose: Port assertions for the macrocell array.
// Assumes: Config is written well before state reads.
// Notes: Shadows the config word from port writes.
`timescale 1ns/10ps
module sop_array_checker
   import sop_array_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_CELLS-1:0] pin_in,
   input wire logic [NUM_CELLS-1:0] pin_out,
   input wire logic [NUM_CELLS-1:0] pin_oe,
   input wire reg_req_t req,
   input wire logic [DATA_W-1:0] rd_data
);
   logic [2*NUM_CELLS-1:0] cfg;
   logic [NUM_CELLS-1:0] comb;
   logic [NUM_CELLS-1:0] pol;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow of the config word
   always_ff @(posedge clk) begin
      if (!rst_n) cfg <= CFG_RESET;
      else if (req.wr && req.addr == CFG_ADDR) cfg <= req.wdata[2*NUM_CELLS-1:0];
   end
   // Split into the two select bits per cell
   always_comb begin
      for (int i = 0; i < NUM_CELLS; i++) begin
         comb[i] = cfg[2*i+1];
         pol[i] = cfg[2*i];
      end
   end
   a_rd_idle_zero: assert property (!$past(req.rd) |-> rd_data == '0) else $error("read data not idle");
   a_reset_quiet: assert property ($rose(rst_n) |-> pin_oe == '0 && pin_out == '0 && rd_data == '0)
      else $error("outputs not cleared");
   a_state_polarity: assert property ($past(req.rd && req.addr == STATE_ADDR)
      |-> ((rd_data[NUM_CELLS-1:0] ^ ~pol ^ $past(pin_out)) & ~comb) == '0) else $error("pin not q");
   a_state_upper: assert property ($past(req.rd && req.addr == STATE_ADDR)
      |-> rd_data[DATA_W-1:NUM_CELLS] == '0) else $error("state upper bits set");
   a_cfg_readback: assert property ($past(req.rd && req.addr == CFG_ADDR) |-> rd_data == DATA_W'($past(cfg)))
      else $error("config readback wrong");
   a_oe_readback: assert property ($past(req.rd && req.addr == PIN_ADDR) |-> rd_data[19:10] == $past(pin_oe))
      else $error("enable readback wrong");
   a_pin_sync: assert property ($past(req.rd && req.addr == PIN_ADDR) && $stable(pin_in)
      && $past(pin_in, 2) == pin_in && $past(pin_in, 3) == pin_in |-> rd_data[9:0] == pin_in)
      else $error("pin level readback wrong");
   a_unmapped_zero: assert property ($past(req.rd && req.addr > PIN_ADDR) |-> rd_data == '0)
      else $error("unmapped read not zero");
endmodule : sop_array_checker

// ==== bench/board_model.sv ====
// Purpose: Board logic driving dedicated inputs and pins.
// Assumes: Undriven pins carry the board's own level.
// Notes: Pin wire resolved from the device enables.
`timescale 1ns/10ps
module board_model
   import sop_array_pkg::*;
(
   input wire logic clk,
   input wire logic [NUM_DED-1:0] ded_val,
   input wire logic [NUM_CELLS-1:0] pin_val,
   input wire logic [NUM_CELLS-1:0] pin_out,
   input wire logic [NUM_CELLS-1:0] pin_oe,
   output logic [NUM_DED-1:0] ded_in,
   output logic [NUM_CELLS-1:0] pin_in
);
   // Inputs change just after a clock edge
   always_ff @(posedge clk) ded_in <= ded_val;
   // Driven pins show the device level, the rest the board level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_val);
endmodule : board_model

// ==== bench/sum_of_products_macrocell_array_tb_top.sv ====
// Purpose: Self-checking bench for the macrocell array.
// Assumes: One 8 ns clock, synchronous reset.
// Notes: Each cell follows one input through its last sum term.
`timescale 1ns/10ps
module sum_of_products_macrocell_array_tb_top
   import sop_array_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [NUM_DED-1:0] ded_val = '0;
   logic [NUM_CELLS-1:0] pin_val = '0;
   logic [NUM_DED-1:0] ded_in;
   logic [NUM_CELLS-1:0] pin_in, pin_out, pin_oe;
   logic [DATA_W-1:0] rd_data;
   reg_req_t req = '0;
   int error_cnt = 0;
   int compares = 0;
   int seed = 32'h1364;
   always #4 clk = ~clk;
   sop_macrocell_array i_dut (.clk(clk), .rst_n(rst_n), .ded_in(ded_in), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .req(req), .rd_data(rd_data));
   board_model i_board (.clk(clk), .ded_val(ded_val), .pin_val(pin_val), .pin_out(pin_out), .pin_oe(pin_oe),
      .ded_in(ded_in), .pin_in(pin_in));
   task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_pin(input logic [NUM_CELLS-1:0] exp, input logic [NUM_CELLS-1:0] got);
      chk("pin", DATA_W'(exp), DATA_W'(got));
   endtask : chk_pin
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk("read", exp, rd_data);
   endtask : rd_chk
   // One product term is two words, low literals first
   task automatic term(input int t, input logic [DATA_W-1:0] lo, input logic [11:0] hi);
      wr(ADDR_W'(2*t), lo);
      wr(ADDR_W'(2*t+1), DATA_W'(hi));
   endtask : term
   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   // Watchdog against a hang
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
   initial begin
      int e;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(STATE_ADDR, '0);
      rd_chk(CFG_ADDR, '0);
      chk_pin(10'h3FF, pin_out);
      rd_chk(9'h108, '0);
      rd_chk(9'h1FF, '0);
      // Every cell: enable true, last sum term is its own input
      for (int i = 0; i < NUM_CELLS; i++) begin
         term(TERM_BASE[i], 32'hFFFFFFFF, 12'hFFF);
         term(TERM_BASE[i] + TERM_CNT[i], ~(32'h00000001 << (2 * i)), 12'hFFF);
      end
      chk_pin(10'h3FF, pin_oe);
      for (int m = 0; m < 4; m++) begin
         wr(CFG_ADDR, DATA_W'({NUM_CELLS{m[1:0]}}));
         repeat (4) begin
            @(posedge clk);
            ded_val <= NUM_DED'($random(seed));
            repeat (6) @(posedge clk);
            e = m[0] ? ded_val[9:0] : ~ded_val[9:0];
            chk_pin(NUM_CELLS'(e), pin_out);
            if (!m[1]) rd_chk(STATE_ADDR, DATA_W'(ded_val[9:0]));
            rd_chk(PIN_ADDR, {12'h000, 10'h3FF, NUM_CELLS'(e)});
         end
      end
      // Disabled pin turns into an input
      term(TERM_BASE[9], '0, '0);
      @(posedge clk);
      pin_val <= NUM_CELLS'($random(seed));
      repeat (6) @(posedge clk);
      chk_pin(10'h1FF, pin_oe);
      rd_chk(PIN_ADDR, {12'h000, 10'h1FF, pin_val[9], pin_out[8:0]});
      // Cell 0 registered: its first sum term is its own state, so a pulse on input 0 latches
      wr(CFG_ADDR, 32'h00055555);
      term(TERM_BASE[0] + 1, ~(32'h00000001 << (2 * NUM_DED)), 12'hFFF);
      @(posedge clk);
      ded_val <= 12'h001;
      repeat (6) @(posedge clk);
      ded_val <= 12'h000;
      repeat (6) @(posedge clk);
      rd_chk(STATE_ADDR, 32'h00000001);
      // Preset sets every register, clear wins over it
      wr(CFG_ADDR, 32'h00055555);
      term(PRESET_TERM, 32'hFFFFFFFF, 12'hFFF);
      rd_chk(STATE_ADDR, 32'h000003FF);
      term(RESET_TERM, 32'hFFFFFFFF, 12'hFFF);
      rd_chk(STATE_ADDR, '0);
      close_out();
   end
endmodule : sum_of_products_macrocell_array_tb_top
bind sop_macrocell_array sop_array_checker i_chk (.clk(clk), .rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .req(req), .rd_data(rd_data));
